// >>> rtl/dspmac_map.svh
`ifndef DSPMAC_MAP_SVH
`define DSPMAC_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DSPMAC_ADDR_STATUS 8'h00
`define DSPMAC_ADDR_OPERAND 8'h04
`define DSPMAC_ADDR_SUM 8'h08
`define DSPMAC_ADDR_PROD_HIGH 8'h0C
`define DSPMAC_ADDR_PROD_LOW 8'h10
`define DSPMAC_ADDR_COMMAND 8'h14
`define DSPMAC_ADDR_BRANCH 8'h18

// ----------------------------------------
// status word fields
// ----------------------------------------
`define DSPMAC_STAT_SXM 0
`define DSPMAC_STAT_OVM 1
`define DSPMAC_STAT_PM_LO 2
`define DSPMAC_STAT_PM_HI 3
`define DSPMAC_STAT_EXCESS 4
`define DSPMAC_STAT_ZERO 5
`define DSPMAC_STAT_TEST 6

// ----------------------------------------
// command word fields
// ----------------------------------------
`define DSPMAC_CMD_OP_LO 0
`define DSPMAC_CMD_OP_HI 4
`define DSPMAC_CMD_SHIFT_LO 5
`define DSPMAC_CMD_SHIFT_HI 9
`define DSPMAC_CMD_IMM_LO 10
`define DSPMAC_CMD_IMM_HI 22
`define DSPMAC_CMD_RPT_LO 23
`define DSPMAC_CMD_RPT_HI 30

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define DSPMAC_SXM_RESET 1'b1
`define DSPMAC_OVM_RESET 1'b0
`define DSPMAC_PM_RESET 2'h0
`define DSPMAC_SAT_POS 32'h7FFFFFFF
`define DSPMAC_SAT_NEG 32'h80000000
`define DSPMAC_MAX_SHIFT 5'h10

`endif

// >>> rtl/dspmac_pkg.sv
package dspmac_pkg;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_LOAD,
    OP_ADD,
    OP_SUB,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_LOAD_T,
    OP_ADD_T,
    OP_SUB_T,
    OP_OPND_LOAD,
    OP_OPND_MOVE_PROD,
    OP_OPND_ADD_PROD,
    OP_OPND_ADD_SHIFT,
    OP_OPND_SUB_PROD,
    OP_SIGNED_MUL,
    OP_SIGNED_MUL_IMM,
    OP_UNSIGNED_MUL,
    OP_SQUARE_ADD,
    OP_SQUARE_SUB,
    OP_MUL_ACCUM,
    OP_MUL_ACCUM_SHIFT,
    OP_BIT_TEST,
    OP_LEAD_ALIGN,
    OP_BR_EXCESS,
    OP_BR_ZERO,
    OP_BR_SUM,
    OP_LOAD_PROD_HIGH
  } dspmac_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_IMM_WAIT,
    ST_RUN
  } dspmac_state_e;

  typedef logic [31:0] dspmac_word_t;

endpackage : dspmac_pkg

// >>> rtl/dspmac_input_scaler.sv
`timescale 1ns/100ps
`default_nettype none
`include "dspmac_map.svh"

module dspmac_input_scaler
  import dspmac_pkg::*;
(
  input wire logic [15:0] dataIn,
  input wire logic [4:0] shiftCount,
  input wire logic signExtend,
  output dspmac_word_t dataOut
);

  logic [31:0] widened;
  logic [4:0] count;

  // upper half filled with sign copies or zeros
  assign widened = {{16{signExtend & dataIn[15]}}, dataIn};
  // counts past sixteen clamp rather than wrap
  assign count = (shiftCount > `DSPMAC_MAX_SHIFT) ? `DSPMAC_MAX_SHIFT
                                                  : shiftCount;
  // pure wiring, no register: no cycle cost on the operand path
  assign dataOut = widened << count;

endmodule : dspmac_input_scaler

`default_nettype wire

// >>> rtl/dspmac_datapath.sv
`timescale 1ns/100ps
`default_nettype none
`include "dspmac_map.svh"

// Function
// - input scaler shifts 16-bit data left 0..16, zero low, sign/zero high
// - scaler count from command shift field or operand register
// - input scaler 16 in, 32 out, adds no cycle
// - 16x16 multiply in one cycle, signed except unsigned multiply
// - 16-bit operand register and 32-bit product register
// - product shift select: none, left 1, left 4, right 6
// - product to ALU or store reads always passes product scaler
// - multiply by 13-bit immediate yields one product per two cycles
// - operand loads run parallel load/add/add-move/subtract of product
// - accumulate ops take both bus operands each cycle, step addresses
// - shifting accumulate copies each sample to next higher address
// - unsigned multiply of operand register by data word into product
// - square ops feed the same data word to both multiplier inputs
// - multiply by immediate zero clears product; high half reloadable
// - ALU takes sum register and scaled product or scaled input
// - shift-by-operand ops use four operand bits as scaler count
// - bit test picks bit by operand low four bits, sum unchanged
// - saturation on overflow sets flag, clamps to most pos/neg value
// - logical operations never overflow nor saturate
// - branch conditions excess and zero; branch target from sum
// - leading bit alignment shifts sum left to normalize
// - left modes zero-fill, right six sign-extends, product untouched
// - without saturation overflowed result wraps into sum register
// - excess flag sticky until reset, excess branch or status reload
// - sign extension mode bit, reset value one
module dspmac_datapath
  import dspmac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] progReadBus,
  input wire logic [15:0] dataReadBus,
  output logic progAddrStep,
  output logic dataAddrStep,
  output logic dataMoveValid,
  output logic [15:0] dataMoveData,
  output logic branchValid,
  output logic [15:0] branchTarget,
  output logic excessCond,
  output logic zeroCond,
  output logic busy
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  dspmac_state_e stateReg;
  dspmac_op_e opReg;
  logic [4:0] shiftReg;
  logic [12:0] immReg;
  logic [7:0] repeatReg;
  logic sxmReg;
  logic ovmReg;
  logic [1:0] pmReg;
  logic excessReg;
  logic testReg;
  logic [15:0] operandReg;
  dspmac_word_t productReg;
  dspmac_word_t sumReg;

  logic exec;
  logic accessPhase;
  logic isCmdAddr;
  logic addrMapped;
  logic wrAccept;
  logic cmdWrite;
  logic statusWrite;
  logic [31:0] readMux;
  logic [31:0] statusWord;

  logic useOperandShift;
  logic [4:0] scalerCount;
  dspmac_word_t scaledIn;
  dspmac_word_t prodScaled;
  logic useProduct;
  logic aluSub;
  dspmac_word_t aluB;
  logic [32:0] sumWide;
  logic arithOverflow;
  dspmac_word_t arithResult;

  logic [15:0] mulA;
  logic [15:0] mulB;
  logic mulSigned;
  logic [31:0] mulAExt;
  logic [31:0] mulBExt;
  dspmac_word_t mulProd;

  logic sumLoad;
  dspmac_word_t sumValue;
  logic excessSet;
  logic excessClear;
  logic prodLoad;
  logic prodHighLoad;
  logic operandLoad;
  logic testLoad;
  logic testValue;
  logic branchFire;
  logic [15:0] branchAddr;
  logic moveSample;
  logic stepAddr;

  assign exec = (stateReg == ST_RUN);
  assign busy = (stateReg != ST_IDLE);

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign accessPhase = psel & penable;
  assign isCmdAddr = (paddr == `DSPMAC_ADDR_COMMAND);
  // a new command waits in the access phase until the last one is done
  assign pready = ~(accessPhase & pwrite & isCmdAddr & busy);
  assign pslverr = accessPhase & pready & ~addrMapped;
  assign wrAccept = accessPhase & pready & pwrite & addrMapped;
  assign cmdWrite = wrAccept & isCmdAddr;
  assign statusWrite = wrAccept & (paddr == `DSPMAC_ADDR_STATUS);

  always_comb begin
    statusWord = 32'h00000000;
    statusWord[`DSPMAC_STAT_SXM] = sxmReg;
    statusWord[`DSPMAC_STAT_OVM] = ovmReg;
    statusWord[`DSPMAC_STAT_PM_HI:`DSPMAC_STAT_PM_LO] = pmReg;
    statusWord[`DSPMAC_STAT_EXCESS] = excessReg;
    statusWord[`DSPMAC_STAT_ZERO] = zeroCond;
    statusWord[`DSPMAC_STAT_TEST] = testReg;
  end

  always_comb begin
    readMux = 32'h00000000;
    addrMapped = 1'b1;
    if (paddr == `DSPMAC_ADDR_STATUS) begin
      readMux = statusWord;
    end else if (paddr == `DSPMAC_ADDR_OPERAND) begin
      readMux = {16'h0000, operandReg};
    end else if (paddr == `DSPMAC_ADDR_SUM) begin
      readMux = sumReg;
    end else if (paddr == `DSPMAC_ADDR_PROD_HIGH) begin
      readMux = {16'h0000, prodScaled[31:16]};
    end else if (paddr == `DSPMAC_ADDR_PROD_LOW) begin
      readMux = {16'h0000, prodScaled[15:0]};
    end else if (paddr == `DSPMAC_ADDR_COMMAND) begin
      readMux = {31'h00000000, busy};
    end else if (paddr == `DSPMAC_ADDR_BRANCH) begin
      readMux = {16'h0000, branchTarget};
    end else begin
      addrMapped = 1'b0;
    end
  end

  // read data is captured in the setup cycle, valid through the access
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      prdata <= readMux;
    end
  end

  // ----------------------------------------
  // scalers
  // ----------------------------------------
  assign useOperandShift = opReg inside {OP_LOAD_T, OP_ADD_T, OP_SUB_T};
  assign scalerCount = useOperandShift ? {1'b0, operandReg[3:0]}
                                       : shiftReg;

  dspmac_input_scaler u_input_scaler (
    .dataIn(dataReadBus),
    .shiftCount(scalerCount),
    .signExtend(sxmReg),
    .dataOut(scaledIn)
  );

  // product register itself is never rewritten by the scaling
  always_comb begin
    case (pmReg)
      2'h0: prodScaled = productReg;
      2'h1: prodScaled = {productReg[30:0], 1'b0};
      2'h2: prodScaled = {productReg[27:0], 4'h0};
      default: prodScaled = {{6{productReg[31]}}, productReg[31:6]};
    endcase
  end

  // ----------------------------------------
  // central alu
  // ----------------------------------------
  assign useProduct = opReg inside {OP_OPND_MOVE_PROD, OP_OPND_ADD_PROD,
    OP_OPND_ADD_SHIFT, OP_OPND_SUB_PROD, OP_SQUARE_ADD, OP_SQUARE_SUB,
    OP_MUL_ACCUM, OP_MUL_ACCUM_SHIFT};
  assign aluSub = opReg inside {OP_SUB, OP_SUB_T, OP_OPND_SUB_PROD,
    OP_SQUARE_SUB};
  assign aluB = useProduct ? prodScaled : scaledIn;
  assign sumWide = aluSub ? {sumReg[31], sumReg} - {aluB[31], aluB}
                          : {sumReg[31], sumReg} + {aluB[31], aluB};
  assign arithOverflow = sumWide[32] ^ sumWide[31];

  always_comb begin
    if (arithOverflow & ovmReg) begin
      arithResult = sumWide[32] ? `DSPMAC_SAT_NEG
                                : `DSPMAC_SAT_POS;
    end else begin
      arithResult = sumWide[31:0];
    end
  end

  // ----------------------------------------
  // multiplier
  // ----------------------------------------
  always_comb begin
    mulA = operandReg;
    mulB = dataReadBus;
    if (opReg inside {OP_SQUARE_ADD, OP_SQUARE_SUB}) begin
      mulA = dataReadBus;
    end else if (opReg inside {OP_MUL_ACCUM, OP_MUL_ACCUM_SHIFT}) begin
      mulA = dataReadBus;
      mulB = progReadBus;
    end else if (opReg == OP_SIGNED_MUL_IMM) begin
      mulB = {{3{immReg[12]}}, immReg};
    end
  end

  assign mulSigned = (opReg != OP_UNSIGNED_MUL);
  // low 32 bits of the widened product serve both signednesses
  assign mulAExt = {{16{mulSigned & mulA[15]}}, mulA};
  assign mulBExt = {{16{mulSigned & mulB[15]}}, mulB};
  assign mulProd = mulAExt * mulBExt;

  // ----------------------------------------
  // operation decode
  // ----------------------------------------
  always_comb begin
    sumLoad = 1'b0;
    sumValue = arithResult;
    excessSet = 1'b0;
    excessClear = 1'b0;
    prodLoad = 1'b0;
    prodHighLoad = 1'b0;
    operandLoad = 1'b0;
    testLoad = 1'b0;
    testValue = 1'b0;
    branchFire = 1'b0;
    branchAddr = progReadBus;
    moveSample = 1'b0;
    stepAddr = 1'b0;
    case (opReg)
      OP_LOAD, OP_LOAD_T: begin
        sumLoad = 1'b1;
        sumValue = scaledIn;
      end
      OP_ADD, OP_SUB, OP_ADD_T, OP_SUB_T: begin
        sumLoad = 1'b1;
        excessSet = arithOverflow;
      end
      OP_AND: begin
        sumLoad = 1'b1;
        sumValue = sumReg & scaledIn;
      end
      OP_OR: begin
        sumLoad = 1'b1;
        sumValue = sumReg | scaledIn;
      end
      OP_XOR: begin
        sumLoad = 1'b1;
        sumValue = sumReg ^ scaledIn;
      end
      OP_OPND_LOAD: begin
        operandLoad = 1'b1;
      end
      OP_OPND_MOVE_PROD: begin
        operandLoad = 1'b1;
        sumLoad = 1'b1;
        sumValue = prodScaled;
      end
      OP_OPND_ADD_PROD, OP_OPND_SUB_PROD: begin
        operandLoad = 1'b1;
        sumLoad = 1'b1;
        excessSet = arithOverflow;
      end
      OP_OPND_ADD_SHIFT: begin
        operandLoad = 1'b1;
        sumLoad = 1'b1;
        excessSet = arithOverflow;
        moveSample = 1'b1;
      end
      OP_SIGNED_MUL, OP_SIGNED_MUL_IMM, OP_UNSIGNED_MUL: begin
        prodLoad = 1'b1;
      end
      OP_SQUARE_ADD, OP_SQUARE_SUB: begin
        operandLoad = 1'b1;
        prodLoad = 1'b1;
        sumLoad = 1'b1;
        excessSet = arithOverflow;
      end
      OP_MUL_ACCUM, OP_MUL_ACCUM_SHIFT: begin
        operandLoad = 1'b1;
        prodLoad = 1'b1;
        sumLoad = 1'b1;
        excessSet = arithOverflow;
        stepAddr = 1'b1;
        moveSample = (opReg == OP_MUL_ACCUM_SHIFT);
      end
      OP_BIT_TEST: begin
        testLoad = 1'b1;
        testValue = dataReadBus[operandReg[3:0]];
      end
      OP_LEAD_ALIGN: begin
        testLoad = 1'b1;
        if ((sumReg == 32'h00000000) | (sumReg[31] ^ sumReg[30])) begin
          testValue = 1'b1;
        end else begin
          sumLoad = 1'b1;
          sumValue = {sumReg[30:0], 1'b0};
        end
      end
      OP_BR_EXCESS: begin
        branchFire = excessReg;
        excessClear = 1'b1;
      end
      OP_BR_ZERO: begin
        branchFire = zeroCond;
      end
      OP_BR_SUM: begin
        branchFire = 1'b1;
        branchAddr = sumReg[15:0];
      end
      OP_LOAD_PROD_HIGH: begin
        prodHighLoad = 1'b1;
      end
      default: begin
        sumLoad = 1'b0;
      end
    endcase
  end

  assign progAddrStep = exec & stepAddr;
  // a moved sample lands one address up, so the data side must advance
  assign dataAddrStep = exec & (stepAddr | moveSample);
  assign excessCond = excessReg;
  assign zeroCond = (sumReg == 32'h00000000);

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stateReg <= ST_IDLE;
      opReg <= OP_NOP;
      shiftReg <= 5'h00;
      immReg <= 13'h0000;
      repeatReg <= 8'h00;
    end else begin
      case (stateReg)
        ST_IDLE: begin
          if (cmdWrite) begin
            opReg <= dspmac_op_e'(pwdata[`DSPMAC_CMD_OP_HI:`DSPMAC_CMD_OP_LO]);
            shiftReg <= pwdata[`DSPMAC_CMD_SHIFT_HI:`DSPMAC_CMD_SHIFT_LO];
            immReg <= pwdata[`DSPMAC_CMD_IMM_HI:`DSPMAC_CMD_IMM_LO];
            repeatReg <= pwdata[`DSPMAC_CMD_RPT_HI:`DSPMAC_CMD_RPT_LO];
            // immediate multiply spends an extra cycle per product
            if (pwdata[`DSPMAC_CMD_OP_HI:`DSPMAC_CMD_OP_LO] ==
                OP_SIGNED_MUL_IMM) begin
              stateReg <= ST_IMM_WAIT;
            end else begin
              stateReg <= ST_RUN;
            end
          end
        end
        ST_IMM_WAIT: begin
          stateReg <= ST_RUN;
        end
        ST_RUN: begin
          if (repeatReg == 8'h00) begin
            stateReg <= ST_IDLE;
          end else begin
            repeatReg <= repeatReg - 8'h01;
            stateReg <= (opReg == OP_SIGNED_MUL_IMM) ? ST_IMM_WAIT : ST_RUN;
          end
        end
        default: begin
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // status bits
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sxmReg <= `DSPMAC_SXM_RESET;
      ovmReg <= `DSPMAC_OVM_RESET;
      pmReg <= `DSPMAC_PM_RESET;
    end else if (statusWrite) begin
      sxmReg <= pwdata[`DSPMAC_STAT_SXM];
      ovmReg <= pwdata[`DSPMAC_STAT_OVM];
      pmReg <= pwdata[`DSPMAC_STAT_PM_HI:`DSPMAC_STAT_PM_LO];
    end
  end

  // a fresh overflow outranks any clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      excessReg <= 1'b0;
    end else if (exec & excessSet) begin
      excessReg <= 1'b1;
    end else if (exec & excessClear) begin
      excessReg <= 1'b0;
    end else if (statusWrite) begin
      excessReg <= pwdata[`DSPMAC_STAT_EXCESS];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      testReg <= 1'b0;
    end else if (exec & testLoad) begin
      testReg <= testValue;
    end else if (statusWrite) begin
      testReg <= pwdata[`DSPMAC_STAT_TEST];
    end
  end

  // ----------------------------------------
  // datapath registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      operandReg <= 16'h0000;
    end else if (exec & operandLoad) begin
      operandReg <= dataReadBus;
    end else if (wrAccept & (paddr == `DSPMAC_ADDR_OPERAND)) begin
      operandReg <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      productReg <= 32'h00000000;
    end else if (exec & prodLoad) begin
      productReg <= mulProd;
    end else if (exec & prodHighLoad) begin
      productReg[31:16] <= dataReadBus;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sumReg <= 32'h00000000;
    end else if (exec & sumLoad) begin
      sumReg <= sumValue;
    end
  end

  // ----------------------------------------
  // outward strobes
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      branchValid <= 1'b0;
      branchTarget <= 16'h0000;
    end else begin
      branchValid <= exec & branchFire;
      if (exec & branchFire) begin
        branchTarget <= branchAddr;
      end
    end
  end

  // the sample moves one cycle late; the memory side owns the address
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dataMoveValid <= 1'b0;
      dataMoveData <= 16'h0000;
    end else begin
      dataMoveValid <= exec & moveSample;
      if (exec & moveSample) begin
        dataMoveData <= dataReadBus;
      end
    end
  end

endmodule : dspmac_datapath

`default_nettype wire

// >>> tb/dspmac_datapath_props.sv
`timescale 1ns/100ps
`default_nettype none
module dspmac_datapath_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic progAddrStep,
  input wire logic dataAddrStep,
  input wire logic dataMoveValid,
  input wire logic branchValid,
  input wire logic excessCond,
  input wire logic zeroCond,
  input wire logic busy
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic acc;
  assign acc = psel && penable;
  property p_wait_cmd;
    !pready |-> acc && pwrite && paddr == 8'h14 && busy;
  endproperty
  a_wait_cmd: assert property (p_wait_cmd) else $error("stray wait");
  property p_unmapped;
    acc && paddr > 8'h18 |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slverr");
  property p_cmd_start;
    acc && pready && pwrite && paddr == 8'h14 |=> busy;
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("no busy");
  property p_zero_read;
    psel && !penable && !pwrite && paddr == 8'h08 && !busy
      |=> (prdata == 32'h0) == zeroCond;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("zero cond");
  property p_step_pair;
    progAddrStep |-> dataAddrStep && busy;
  endproperty
  a_step_pair: assert property (p_step_pair) else $error("step pair");
  property p_move_after;
    dataMoveValid |-> $past(dataAddrStep);
  endproperty
  a_move_after: assert property (p_move_after) else $error("move");
  property p_sticky;
    excessCond && !busy && !(acc && pwrite && paddr == 8'h00) |=> excessCond;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_branch_after;
    branchValid |-> $past(busy);
  endproperty
  a_branch_after: assert property (p_branch_after) else $error("branch");
  c_done: cover property (busy ##1 !busy);
  c_move: cover property (dataMoveValid);
  c_excess: cover property (excessCond);
endmodule : dspmac_datapath_props
bind dspmac_datapath dspmac_datapath_props chk (.clk_sys(clk_sys),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .progAddrStep(progAddrStep), .dataAddrStep(dataAddrStep),
  .dataMoveValid(dataMoveValid), .branchValid(branchValid),
  .excessCond(excessCond), .zeroCond(zeroCond), .busy(busy));
`default_nettype wire

// >>> tb/dspmac_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module dspmac_far_model (
  input wire logic clk_sys,
  input wire logic progAddrStep,
  input wire logic dataAddrStep,
  input wire logic dataMoveValid,
  input wire logic [15:0] dataMoveData,
  output logic [15:0] progReadBus,
  output logic [15:0] dataReadBus
);
  logic [15:0] progMem [0:15];
  logic [15:0] dataMem [0:15];
  logic [3:0] pAddr = 4'h0;
  logic [3:0] dAddr = 4'h0;
  int moves = 0;
  assign progReadBus = progMem[pAddr];
  assign dataReadBus = dataMem[dAddr];
  task rewind();
    pAddr = 4'h0;
    dAddr = 4'h0;
    moves = 0;
  endtask : rewind
  // move lands at the word now addressed, one above the one read
  always @(posedge clk_sys) begin
    if (progAddrStep) pAddr <= pAddr + 4'h1;
    if (dataAddrStep) dAddr <= dAddr + 4'h1;
    if (dataMoveValid) begin
      dataMem[dAddr] <= dataMoveData;
      moves++;
    end
  end
endmodule : dspmac_far_model
`default_nettype wire

// >>> tb/dsp_multiply_accumulate_datapath_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dsp_multiply_accumulate_datapath_bench;
  import dspmac_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, progAddrStep, dataAddrStep, dataMoveValid, errSeen;
  logic branchValid, excessCond, zeroCond, busy;
  logic [15:0] progReadBus, dataReadBus, dataMoveData, branchTarget;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int nBusy;
  int nBranch = 0;
  dspmac_datapath uut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progReadBus(progReadBus), .dataReadBus(dataReadBus),
    .progAddrStep(progAddrStep), .dataAddrStep(dataAddrStep),
    .dataMoveValid(dataMoveValid), .dataMoveData(dataMoveData),
    .branchValid(branchValid), .branchTarget(branchTarget),
    .excessCond(excessCond), .zeroCond(zeroCond), .busy(busy));
  dspmac_far_model far (.clk_sys(clk_sys), .progAddrStep(progAddrStep),
    .dataAddrStep(dataAddrStep), .dataMoveValid(dataMoveValid),
    .dataMoveData(dataMoveData), .progReadBus(progReadBus),
    .dataReadBus(dataReadBus));
  initial forever #20 clk_sys = ~clk_sys;
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] scl(logic [15:0] d, int s, logic x);
    return {(x ? {16{d[15]}} : 16'h0), d} << s;
  endfunction : scl
  function automatic logic [31:0] psc(logic [31:0] p, logic [1:0] m);
    case (m)
      2'h1: return p << 1;
      2'h2: return p << 4;
      2'h3: return 32'($signed(p) >>> 6);
      default: return p;
    endcase
  endfunction : psc
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(negedge clk_sys);
    while (pready !== 1'b1 && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 500) begin
      errors++;
      $display("[ERR] %0t no pready", $time);
    end
    @(posedge clk_sys);
    rdv = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rd
  task automatic cmd(int op, int sh, int imm, int rep);
    apb(1'b1, 8'h14, {1'b0, 8'(rep), 13'(imm), 5'(sh), 5'(op)});
    nBusy = 0;
    @(negedge clk_sys);
    while (busy === 1'b1 && nBusy < 600) begin
      nBusy++;
      @(negedge clk_sys);
    end
    if (nBusy == 600) begin
      errors++;
      $display("[ERR] %0t busy stuck", $time);
    end
  endtask : cmd
  // bounded run: a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (branchValid === 1'b1) nBranch <= nBranch + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  // ----------
  // tests
  // ----------
  initial begin
    logic [15:0] d, a;
    logic [31:0] p, acc;
    int s;
    void'($urandom(32'hDC540CF4));
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h00, 32'h21);
    rd(8'h08, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      d = 16'($urandom);
      s = (i < 2) ? 16 : $urandom_range(16);
      apb(1'b1, 8'h00, {31'h0, i[1]});
      apb(1'b1, 8'h04, 32'(s));
      far.dataMem[0] = d;
      cmd(i[0] ? 7 : 1, i[0] ? 0 : s, 0, 0);
      rd(8'h08, scl(d, i[0] ? s % 16 : s, i[1]));
    end
    $display("test scaler done");
    for (int i = 0; i < 8; i++) begin
      a = 16'($urandom);
      d = 16'($urandom);
      apb(1'b1, 8'h00, {28'h0, 2'(i), 2'h1});
      apb(1'b1, 8'h04, {16'h0, a});
      far.dataMem[0] = d;
      cmd(i < 4 ? 15 : 17, 0, 0, 0);
      acc = {16'h0, a} * {16'h0, d};
      if (i < 4) acc = 32'($signed(a)) * 32'($signed(d));
      p = psc(acc, 2'(i));
      rd(8'h0C, {16'h0, p[31:16]});
      rd(8'h10, {16'h0, p[15:0]});
    end
    apb(1'b1, 8'h00, 32'h1);
    rd(8'h10, {16'h0, acc[15:0]});
    apb(1'b1, 8'h04, 32'h3);
    cmd(16, 0, 13'h1FFE, 2);
    chk(32'(nBusy), 32'h6);
    rd(8'h10, 32'hFFFA);
    cmd(16, 0, 0, 0);
    rd(8'h0C, 32'h0);
    $display("test multiply done");
    far.dataMem[0] = 16'h7FFF;
    far.progMem[0] = 16'h0123;
    for (int o = 0; o < 2; o++) begin
      apb(1'b1, 8'h00, o == 0 ? 32'h3 : 32'h1);
      cmd(1, 16, 0, 0);
      cmd(2, 16, 0, 0);
      rd(8'h08, o == 0 ? 32'h7FFFFFFF : 32'hFFFE0000);
      rd(8'h00, o == 0 ? 32'h13 : 32'h11);
      cmd(24, 0, 0, 0);
      rd(8'h00, o == 0 ? 32'h3 : 32'h1);
      rd(8'h18, 32'h123);
    end
    apb(1'b1, 8'h00, 32'h3);
    cmd(6, 16, 0, 0);
    rd(8'h08, 32'h80010000);
    rd(8'h00, 32'h3);
    $display("test saturate done");
    apb(1'b1, 8'h00, 32'h1);
    far.dataMem[0] = 16'h0;
    cmd(1, 0, 0, 0);
    cmd(16, 0, 0, 0);
    acc = 32'h0;
    for (int i = 0; i < 5; i++) begin
      far.dataMem[i] = 16'($urandom);
      far.progMem[i] = 16'($urandom);
      p = 32'($signed(far.dataMem[i])) * 32'($signed(far.progMem[i]));
      if (i < 4) acc = acc + p;
    end
    d = far.dataMem[4];
    far.rewind();
    cmd(21, 0, 0, 4);
    rd(8'h08, acc);
    chk(32'(far.moves), 32'h5);
    chk({16'h0, far.dataMem[5]}, {16'h0, d});
    far.rewind();
    $display("test accumulate done");
    for (int i = 0; i < 4; i++) begin
      s = $urandom_range(15);
      d = 16'($urandom);
      far.dataMem[0] = d;
      apb(1'b1, 8'h04, 32'(s));
      cmd(22, 0, 0, 0);
      apb(1'b0, 8'h00, 32'h0);
      chk({31'h0, rdv[6]}, {31'h0, d[s]});
    end
    rd(8'h08, acc);
    cmd(26, 0, 0, 0);
    rd(8'h18, {16'h0, acc[15:0]});
    far.dataMem[0] = 16'h1234;
    cmd(1, 0, 0, 0);
    cmd(23, 0, 0, 1);
    rd(8'h08, 32'h48D0);
    cmd(16, 0, 0, 0);
    cmd(18, 0, 0, 0);
    rd(8'h0C, 32'h014B);
    rd(8'h10, 32'h5A90);
    cmd(12, 0, 0, 0);
    rd(8'h08, 32'h014BA360);
    rd(8'h04, 32'h1234);
    cmd(27, 0, 0, 0);
    rd(8'h0C, 32'h1234);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, errSeen}, 32'h1);
    chk(32'(nBranch), 32'h3);
    $display("test misc done");
    close_out();
  end
endmodule : dsp_multiply_accumulate_datapath_bench
`default_nettype wire
